// ### core/lane_drive_pkg.sv
package lane_drive_pkg;

   // Register offsets
   localparam logic [7:0] clock_lane_drive_config_offset     = 8'h12;
   localparam logic [7:0] clock_lane_equalizer_config_offset = 8'h13;
   localparam logic [7:0] lane0_drive_config_offset          = 8'h14;
   localparam logic [7:0] lane0_equalizer_config_offset      = 8'h15;
   localparam logic [7:0] lane1_drive_config_offset          = 8'h16;
   localparam logic [7:0] lane1_equalizer_config_offset      = 8'h17;

   // Reset values
   localparam logic [7:0] drive_config_reset     = 8'h03;
   localparam logic [7:0] equalizer_config_reset = 8'h00;

   // Field positions
   localparam int preemphasis_lsb = 4;
   localparam int preemphasis_msb = 6;
   localparam int swing_lsb       = 0;
   localparam int swing_msb       = 2;
   localparam int equalizer_lsb   = 0;
   localparam int equalizer_msb   = 3;

   // Writable bit masks; reserved bits read zero
   localparam logic [7:0] drive_config_mask     = 8'h77;
   localparam logic [7:0] equalizer_config_mask = 8'h0f;

   // Pre-emphasis codes
   localparam logic [2:0] preemphasis_reserved_code = 3'h3;
   localparam logic [2:0] preemphasis_zero_code     = 3'h0;

   // Swing codes
   localparam logic [2:0] swing_nominal_code    = 3'h3;
   localparam logic [2:0] swing_first_step_code = 3'h4;

   // Swing override field value that hands control to the lane fields
   localparam logic [1:0] swing_override_use_lane = 2'h0;

   // Nominal swing, linear base and linear step in mV
   localparam logic [11:0] clock_limited_nominal_mv = 12'd800;
   localparam logic [11:0] data_limited_nominal_mv  = 12'd1000;
   localparam logic [11:0] linear_nominal_mv        = 12'd1200;
   localparam logic [11:0] linear_base_mv           = 12'd800;
   localparam logic [11:0] linear_step_mv           = 12'd100;

   typedef enum logic [1:0] {
      mode_legacy14,
      mode_legacy20,
      mode_fixed_rate_link
   } link_mode_type;

   // Pre-emphasis in tenths of dB, signed
   typedef struct packed {
      logic              valid;
      logic signed [7:0] tenth_db;
   } preemphasis_setting_type;

   // Swing setting to analog lane
   typedef struct packed {
      logic              valid;
      logic              linear;
      logic              use_mode_default;
      logic              absolute;
      logic [11:0]       millivolt;
      logic signed [7:0] percent;
   } swing_setting_type;

   typedef struct packed {
      logic                    enable_extra;
      preemphasis_setting_type preemphasis;
      swing_setting_type       swing;
      logic [3:0]              equalizer;
   } lane_setting_type;

endpackage

// ### core/lane_setting_decode.sv
`timescale 1ns/1ps
module lane_setting_decode
   import lane_drive_pkg::*;
#(
   parameter logic [11:0] limited_nominal_mv = 12'd1000
) (
   // Register fields
   input  wire logic [2:0]       preemphasis_code,
   input  wire logic [2:0]       swing_code,
   input  wire logic [3:0]       equalizer_code,
   // Global controls
   input  wire logic             linear_select,
   input  wire logic             override_active,
   input  wire logic             honor_extra,
   // Decoded setting
   output lane_setting_type      setting
);

   wire logic signed [7:0] preemphasis_tenths;
   wire logic signed [7:0] limited_percent;
   wire logic              swing_upper;
   wire logic [11:0]       linear_mv;

   assign preemphasis_tenths =
      (preemphasis_code == 3'h0) ? 8'sd0   :
      (preemphasis_code == 3'h1) ? 8'sd35  :
      (preemphasis_code == 3'h2) ? 8'sd60  :
      (preemphasis_code == 3'h4) ? -8'sd15 :
      (preemphasis_code == 3'h5) ? -8'sd25 :
      (preemphasis_code == 3'h6) ? -8'sd35 :
      (preemphasis_code == 3'h7) ? -8'sd48 : 8'sd0;

   assign swing_upper = (swing_code >= swing_first_step_code);

   assign limited_percent =
      (swing_code == 3'h0) ? -8'sd15 :
      (swing_code == 3'h1) ? -8'sd10 :
      (swing_code == 3'h2) ? -8'sd5  :
      (swing_code == 3'h4) ? 8'sd5   :
      (swing_code == 3'h5) ? 8'sd10  :
      (swing_code == 3'h6) ? 8'sd15  :
      (swing_code == 3'h7) ? 8'sd20  : 8'sd0;

   assign linear_mv = (swing_code == swing_nominal_code) ? linear_nominal_mv :
      12'(linear_base_mv + linear_step_mv * 12'(swing_code));

   always_comb begin
      setting                        = '0;
      setting.enable_extra           = honor_extra;
      setting.equalizer              = honor_extra ? equalizer_code : 4'h0;
      setting.preemphasis.valid      = honor_extra && (preemphasis_code != preemphasis_reserved_code);
      setting.preemphasis.tenth_db   = honor_extra ? preemphasis_tenths : 8'sd0;
      setting.swing.linear           = linear_select;
      if (linear_select) begin
         setting.swing.valid         = !swing_upper;
         setting.swing.absolute      = 1'b1;
         setting.swing.millivolt     = swing_upper ? 12'h000 : linear_mv;
      end else if (override_active) begin
         setting.swing.valid         = 1'b1;
         setting.swing.use_mode_default = 1'b1;
      end else begin
         setting.swing.valid         = 1'b1;
         setting.swing.absolute      = (swing_code == swing_nominal_code);
         setting.swing.millivolt     = limited_nominal_mv;
         setting.swing.percent       = limited_percent;
      end
   end

endmodule

// ### core/lane_drive_config_regs.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Clock pre-emphasis bits 6:4, fixed-rate mode only
// - Pre-emphasis codes decode to seven dB levels, code 3 reserved
// - Lane 1 has own pre-emphasis, swing fields
// - Clock swing bits 2:0, resets 3
// - Lane 0 swing code 3 1000/1200mV
// - Swing codes 4-7 steps limited, reserved linear
// - Clock equalizer bits 3:0, fixed-rate mode only
// - Lane 0 and 1 equalizers bits 3:0
// - Lane 1 equalizer low nibble, upper reserved
// - Global bit 7 selects limited or linear
// - Legacy modes in limited swing use lane swing only when override zero
module lane_drive_config_regs
   import lane_drive_pkg::*;
(
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             rst,
   // Register port
   input  wire logic [7:0]       reg_address,
   input  wire logic [7:0]       reg_write_data,
   input  wire logic             reg_write,
   input  wire logic             reg_read,
   output      logic [7:0]       reg_read_data,
   // Controls from the rest of the register map
   input  wire logic [7:0]       global_control,
   input  wire logic [1:0]       mode14_swing_override,
   input  wire logic [1:0]       mode20_swing_override,
   input  link_mode_type         link_mode,
   // Settings to analog lanes
   output lane_setting_type      clock_lane_setting,
   output lane_setting_type      lane0_setting,
   output lane_setting_type      lane1_setting
);

   localparam int global_linear_bit = 7;

   logic [7:0] clock_lane_drive_config;
   logic [7:0] clock_lane_equalizer_config;
   logic [7:0] lane0_drive_config;
   logic [7:0] lane0_equalizer_config;
   logic [7:0] lane1_drive_config;
   logic [7:0] lane1_equalizer_config;
   logic [7:0] next_read_data;

   lane_setting_type next_clock_setting;
   lane_setting_type next_lane0_setting;
   lane_setting_type next_lane1_setting;

   wire logic hit_clock_drive = (reg_address == clock_lane_drive_config_offset);
   wire logic hit_clock_eq    = (reg_address == clock_lane_equalizer_config_offset);
   wire logic hit_lane0_drive = (reg_address == lane0_drive_config_offset);
   wire logic hit_lane0_eq    = (reg_address == lane0_equalizer_config_offset);
   wire logic hit_lane1_drive = (reg_address == lane1_drive_config_offset);
   wire logic hit_lane1_eq    = (reg_address == lane1_equalizer_config_offset);

   wire logic global_linear_select = global_control[global_linear_bit];
   wire logic fixed_rate_link      = (link_mode == mode_fixed_rate_link);

   // Override only matters for limited mode in legacy modes
   wire logic override_active =
      ((link_mode == mode_legacy14) && (mode14_swing_override != swing_override_use_lane)) ||
      ((link_mode == mode_legacy20) && (mode20_swing_override != swing_override_use_lane));

   wire logic [7:0] drive_write_value = reg_write_data & drive_config_mask;
   wire logic [7:0] eq_write_value    = reg_write_data & equalizer_config_mask;

   // Field extraction
   wire logic [2:0] clock_lane_preemphasis =
      clock_lane_drive_config[preemphasis_msb:preemphasis_lsb];
   wire logic [2:0] clock_lane_swing  = clock_lane_drive_config[swing_msb:swing_lsb];
   wire logic [3:0] clock_lane_equalizer =
      clock_lane_equalizer_config[equalizer_msb:equalizer_lsb];
   wire logic [2:0] lane0_preemphasis = lane0_drive_config[preemphasis_msb:preemphasis_lsb];
   wire logic [2:0] lane0_swing       = lane0_drive_config[swing_msb:swing_lsb];
   wire logic [3:0] lane0_equalizer   = lane0_equalizer_config[equalizer_msb:equalizer_lsb];
   wire logic [2:0] lane1_preemphasis = lane1_drive_config[preemphasis_msb:preemphasis_lsb];
   wire logic [2:0] lane1_swing       = lane1_drive_config[swing_msb:swing_lsb];
   wire logic [3:0] lane1_equalizer   = lane1_equalizer_config[equalizer_msb:equalizer_lsb];

   // Register writes
   always_ff @(posedge mclk) begin
      if (rst) begin
         clock_lane_drive_config     <= drive_config_reset;
         clock_lane_equalizer_config <= equalizer_config_reset;
         lane0_drive_config          <= drive_config_reset;
         lane0_equalizer_config      <= equalizer_config_reset;
         lane1_drive_config          <= drive_config_reset;
         lane1_equalizer_config      <= equalizer_config_reset;
      end else if (reg_write) begin
         if (hit_clock_drive) begin
            clock_lane_drive_config <= drive_write_value;
         end
         if (hit_clock_eq) begin
            clock_lane_equalizer_config <= eq_write_value;
         end
         if (hit_lane0_drive) begin
            lane0_drive_config <= drive_write_value;
         end
         if (hit_lane0_eq) begin
            lane0_equalizer_config <= eq_write_value;
         end
         if (hit_lane1_drive) begin
            lane1_drive_config <= drive_write_value;
         end
         if (hit_lane1_eq) begin
            lane1_equalizer_config <= eq_write_value;
         end
      end
   end

   // Read mux; unmapped addresses read zero
   assign next_read_data =
      hit_clock_drive ? clock_lane_drive_config     :
      hit_clock_eq    ? clock_lane_equalizer_config :
      hit_lane0_drive ? lane0_drive_config          :
      hit_lane0_eq    ? lane0_equalizer_config      :
      hit_lane1_drive ? lane1_drive_config          :
      hit_lane1_eq    ? lane1_equalizer_config      : 8'h00;

   always_ff @(posedge mclk) begin
      if (rst) begin
         reg_read_data <= 8'h00;
      end else begin
         reg_read_data <= reg_read ? next_read_data : 8'h00;
      end
   end

   // Clock lane: pre-emphasis and equalizer honored only in fixed-rate link
   lane_setting_decode #(
      .limited_nominal_mv (clock_limited_nominal_mv)
   ) clock_decode (
      .preemphasis_code (clock_lane_preemphasis),
      .swing_code       (clock_lane_swing),
      .equalizer_code   (clock_lane_equalizer),
      .linear_select    (global_linear_select),
      .override_active  (override_active),
      .honor_extra      (fixed_rate_link),
      .setting          (next_clock_setting)
   );

   lane_setting_decode #(
      .limited_nominal_mv (data_limited_nominal_mv)
   ) lane0_decode (
      .preemphasis_code (lane0_preemphasis),
      .swing_code       (lane0_swing),
      .equalizer_code   (lane0_equalizer),
      .linear_select    (global_linear_select),
      .override_active  (override_active),
      .honor_extra      (1'b1),
      .setting          (next_lane0_setting)
   );

   lane_setting_decode #(
      .limited_nominal_mv (data_limited_nominal_mv)
   ) lane1_decode (
      .preemphasis_code (lane1_preemphasis),
      .swing_code       (lane1_swing),
      .equalizer_code   (lane1_equalizer),
      .linear_select    (global_linear_select),
      .override_active  (override_active),
      .honor_extra      (1'b1),
      .setting          (next_lane1_setting)
   );

   // Settings registered toward the analog lanes
   always_ff @(posedge mclk) begin
      if (rst) begin
         clock_lane_setting <= '0;
         lane0_setting      <= '0;
         lane1_setting      <= '0;
      end else begin
         clock_lane_setting <= next_clock_setting;
         lane0_setting      <= next_lane0_setting;
         lane1_setting      <= next_lane1_setting;
      end
   end

endmodule

// ### dv/lane_drive_config_regs_props.sv
`timescale 1ns/1ps
module lane_drive_config_regs_props
   import lane_drive_pkg::*;
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   // Register port
   input wire logic [7:0]  reg_address,
   input wire logic [7:0]  reg_write_data,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_read_data,
   // Global controls
   input wire logic [7:0]  global_control,
   input wire logic [1:0]  mode14_swing_override,
   input wire logic [1:0]  mode20_swing_override,
   input link_mode_type    link_mode,
   // Settings
   input lane_setting_type clock_lane_setting,
   input lane_setting_type lane0_setting,
   input lane_setting_type lane1_setting
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   wire drv = reg_address inside {8'h12, 8'h14, 8'h16};
   wire eqr = reg_address inside {8'h13, 8'h15, 8'h17};
   wire fix = link_mode == mode_fixed_rate_link;
   wire ovr = link_mode == mode_legacy14 && mode14_swing_override != 2'h0;
   sequence eq_wr_s;
      reg_write && reg_address == 8'h15;
   endsequence
   sequence eq_rd_s;
      reg_read && reg_address == 8'h15;
   endsequence
   rd_idle_zero_a: assert property (!$past(reg_read) |-> reg_read_data == 8'h00)
      else $error("read data not zero outside read");
   rd_unmapped_a: assert property (reg_read && !drv && !eqr |=> reg_read_data == 8'h00)
      else $error("unmapped read not zero");
   drv_rsvd_a: assert property (reg_read && drv |=> reg_read_data[7] == 1'b0 && reg_read_data[3] == 1'b0)
      else $error("drive reserved bits not zero");
   eq_rsvd_a: assert property (reg_read && eqr |=> reg_read_data[7:4] == 4'h0)
      else $error("equalizer reserved bits not zero");
   eq_back_a: assert property (eq_wr_s ##1 eq_rd_s |=> reg_read_data == ($past(reg_write_data, 2) & 8'h0f))
      else $error("equalizer readback wrong");
   clk_gate_a: assert property (!fix |=> !clock_lane_setting.enable_extra && !clock_lane_setting.preemphasis.valid)
      else $error("clock extras honoured outside fixed rate");
   clk_open_a: assert property (fix && !rst |=> clock_lane_setting.enable_extra)
      else $error("clock extras ignored in fixed rate");
   lin_sel_a: assert property (!$past(rst) |-> lane0_setting.swing.linear == $past(global_control[7]))
      else $error("linear select not followed");
   ovr_use_a: assert property (ovr && !global_control[7] && !rst |=> lane0_setting.swing.use_mode_default)
      else $error("override not applied");
endmodule
bind lane_drive_config_regs lane_drive_config_regs_props chk (.*);

// ### dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import lane_drive_pkg::*;
   logic             mclk, rst, reg_write, reg_read;
   logic [7:0]       reg_address, reg_write_data, reg_read_data, global_control, d;
   logic [1:0]       mode14_swing_override, mode20_swing_override;
   link_mode_type    link_mode;
   lane_setting_type clock_lane_setting, lane0_setting, lane1_setting;
   int               failures = 0;
   int               n_tests = 0;
   int               pct [8] = '{-15, -10, -5, 0, 5, 10, 15, 20};
   int               db [8] = '{0, 35, 60, 0, -15, -25, -35, -48};
   lane_drive_config_regs uut (.*);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      #1 reg_write <= 1'b1;
      reg_address <= a;
      reg_write_data <= v;
      @(posedge mclk) reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      #1 reg_read <= 1'b1;
      reg_address <= a;
      @(posedge mclk) reg_read <= 1'b0;
      #1 d = reg_read_data;
   endtask
   task automatic settle;
      repeat (3) @(posedge mclk);
      #1;
   endtask
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         rd(8'h12 + 8'(i));
         chk("reset value", (i % 2) ? 12'h000 : 12'h003, 12'(d));
      end
      $display("test reset done");
   endtask
   task automatic t_access;
      for (int i = 0; i < 6; i++) begin
         wr(8'h12 + 8'(i), 8'hff);
         rd(8'h12 + 8'(i));
         chk("masked readback", (i % 2) ? 12'h00f : 12'h077, 12'(d));
      end
      settle;
      chk("lane1 equalizer", 12'h00f, 12'(lane1_setting.equalizer));
      wr(8'h11, 8'hff);
      rd(8'h11);
      chk("unmapped low", 12'h000, 12'(d));
      wr(8'h18, 8'hff);
      rd(8'h18);
      chk("unmapped high", 12'h000, 12'(d));
      wr(8'h15, 8'ha6);
      rd(8'h15);
      chk("lane0 equalizer", 12'h006, 12'(d));
      $display("test access done");
   endtask
   task automatic t_midreset;
      wr(8'h14, 8'h55);
      rd(8'h14);
      chk("lane0 drive before reset", 12'h055, 12'(d));
      rst <= 1'b1;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      rd(8'h14);
      chk("lane0 drive after reset", 12'h003, 12'(d));
      rd(8'h17);
      chk("lane1 equalizer after reset", 12'h000, 12'(d));
      settle;
      chk("lane0 nominal mv", 12'd1000, lane0_setting.swing.millivolt);
      $display("test midreset done");
   endtask
   task automatic t_preemph;
      for (int c = 0; c < 8; c++) begin
         wr(8'h12, 8'(c * 16 + 3));
         wr(8'h14, 8'(c * 16 + 3));
         wr(8'h16, 8'(c * 16 + 3));
         settle;
         chk("lane0 valid", 12'(c != 3), 12'(lane0_setting.preemphasis.valid));
         chk("lane0 db", {4'h0, 8'(db[c])}, {4'h0, lane0_setting.preemphasis.tenth_db});
         chk("lane1 db", {4'h0, 8'(db[c])}, {4'h0, lane1_setting.preemphasis.tenth_db});
         chk("clock db", {4'h0, 8'(db[c])}, {4'h0, clock_lane_setting.preemphasis.tenth_db});
      end
      wr(8'h13, 8'h0f);
      settle;
      chk("clock equalizer", 12'h00f, 12'(clock_lane_setting.equalizer));
      link_mode <= mode_legacy20;
      settle;
      chk("clock extra gated", 12'h000, 12'(clock_lane_setting.enable_extra));
      chk("clock preemphasis gated", 12'h000, 12'(clock_lane_setting.preemphasis.valid));
      chk("clock equalizer gated", 12'h000, 12'(clock_lane_setting.equalizer));
      chk("lane0 extra kept", 12'h001, 12'(lane0_setting.enable_extra));
      link_mode <= mode_fixed_rate_link;
      $display("test preemphasis done");
   endtask
   task automatic t_swing;
      logic [11:0] mv;
      for (int l = 0; l < 2; l++) begin
         for (int c = 0; c < 8; c++) begin
            global_control <= l ? 8'h80 : 8'h00;
            wr(8'h12, 8'(c));
            wr(8'h14, 8'(c));
            wr(8'h16, 8'(c));
            settle;
            mv = (c == 3) ? 12'd1200 : 12'(800 + 100 * c);
            chk("swing valid", 12'(!(l && c > 3)), 12'(lane0_setting.swing.valid));
            chk("swing linear", 12'(l), 12'(lane0_setting.swing.linear));
            chk("swing absolute", 12'(l || c == 3), 12'(lane0_setting.swing.absolute));
            if (l && c < 4) begin
               chk("lane0 linear mv", mv, lane0_setting.swing.millivolt);
               chk("lane1 linear mv", mv, lane1_setting.swing.millivolt);
               chk("clock linear mv", mv, clock_lane_setting.swing.millivolt);
            end
            if (!l) begin
               chk("lane0 limited mv", 12'd1000, lane0_setting.swing.millivolt);
               chk("clock limited mv", 12'd800, clock_lane_setting.swing.millivolt);
            end
            if (!l && c != 3) begin
               chk("limited step", {4'h0, 8'(pct[c])}, {4'h0, lane0_setting.swing.percent});
               chk("lane1 step", {4'h0, 8'(pct[c])}, {4'h0, lane1_setting.swing.percent});
            end
         end
      end
      $display("test swing done");
   endtask
   task automatic ov(input link_mode_type m, input logic [1:0] a, b, input logic l, e);
      link_mode <= m;
      mode14_swing_override <= a;
      mode20_swing_override <= b;
      global_control <= {l, 7'h00};
      settle;
      chk("mode default", 12'(e), 12'(lane0_setting.swing.use_mode_default));
   endtask
   task automatic t_override;
      ov(mode_legacy14, 2'h1, 2'h0, 1'b0, 1'b1);
      ov(mode_legacy14, 2'h0, 2'h3, 1'b0, 1'b0);
      ov(mode_legacy20, 2'h0, 2'h2, 1'b0, 1'b1);
      ov(mode_legacy20, 2'h3, 2'h2, 1'b1, 1'b0);
      ov(mode_fixed_rate_link, 2'h1, 2'h1, 1'b0, 1'b0);
      $display("test override done");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      {reg_write, reg_read, reg_address, reg_write_data, global_control} = '0;
      {mode14_swing_override, mode20_swing_override} = '0;
      link_mode = mode_fixed_rate_link;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      t_reset;
      t_access;
      t_midreset;
      t_preemph;
      t_swing;
      t_override;
      results;
   end
   initial begin
      #500000;
      failures++;
      results;
   end
endmodule
